// ### core/asr_defines.svh
// Purpose: Timing figures and pin widths for the static memory host.
// Assumes: A 125 MHz host clock and the slowest speed grade of the memory.
// Notes: Every count is rounded up to whole cycles and is at least one.
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// Widths of the memory pins and of the phase timer count.
`define ASR_ADDR_W 16
`define ASR_DATA_W 4
`define ASR_CNT_W 4

// Host clock period in nanoseconds.
`define ASR_CLK_NS 8

// Memory timing in nanoseconds, slowest grade.
`define ASR_T_READ_ACCESS_NS 45
`define ASR_T_WRITE_PULSE_NS 40
`define ASR_T_ENABLE_TO_WRITE_END_NS 40
`define ASR_T_DATA_SETUP_NS 20
`define ASR_T_STROBE_TO_OUTPUT_FLOAT_NS 20
`define ASR_T_DESELECT_FLOAT_NS 20
`define ASR_T_ADDRESS_HOLD_AFTER_WRITE_NS 2
`define ASR_T_ADDRESS_LEAD_BEFORE_WRITE_NS 0
`define ASR_T_OUTPUT_REENABLE_AFTER_WRITE_NS 5

// A least time in cycles: rounded up, never below one cycle.
`define ASR_CYC_MIN(ns) (((ns) + `ASR_CLK_NS - 1) / `ASR_CLK_NS < 1 ? 1 : \
	((ns) + `ASR_CLK_NS - 1) / `ASR_CLK_NS)

// Cycle counts used by the sequencer.
`define ASR_CYC_READ_ACCESS `ASR_CYC_MIN(`ASR_T_READ_ACCESS_NS)
`define ASR_CYC_FLOAT `ASR_CYC_MIN(`ASR_T_STROBE_TO_OUTPUT_FLOAT_NS)
`define ASR_CYC_WRITE_LOW `ASR_CYC_MIN(`ASR_T_ENABLE_TO_WRITE_END_NS)
`define ASR_CYC_ADDR_HOLD `ASR_CYC_MIN(`ASR_T_ADDRESS_HOLD_AFTER_WRITE_NS)

`endif

// ### core/asr_pkg.sv
// Purpose: Types shared by the static memory host files.
// Assumes: The defines header is on the include path.
// Notes: Pins and requests travel as packed structs.
`include "asr_defines.svh"

package asr_pkg;

	// Sequencer states, one-hot.
	typedef enum logic [5:0] {
		ASR_IDLE = 6'h01,
		ASR_READ = 6'h02,
		ASR_WR_STROBE = 6'h04,
		ASR_WR_DATA = 6'h08,
		ASR_WR_HOLD = 6'h10,
		ASR_SPARE = 6'h20
	} asr_state_t;

	// Pins driven toward the memory.
	typedef struct packed {
		logic sel_n;
		logic we_n;
		logic [`ASR_ADDR_W-1:0] word_address_lines;
		logic [`ASR_DATA_W-1:0] dq_out;
		logic dq_oe;
	} asr_pins_t;

	// One user request.
	typedef struct packed {
		logic we;
		logic [`ASR_ADDR_W-1:0] addr;
		logic [`ASR_DATA_W-1:0] wdata;
	} asr_req_t;

	// State of the interval timer.
	typedef struct packed {
		logic [`ASR_CNT_W-1:0] cnt;
		logic done;
		logic near;
	} asr_tmr_t;

endpackage

// ### core/asr_timer.sv
// Purpose: Down counter that times each strobe phase.
// Assumes: Load values are at least one.
// Notes: Done rises load value edges after the load edge.
`timescale 1ns/1ns
`include "asr_defines.svh"

module asr_timer
	import asr_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic load,
	input wire logic [`ASR_CNT_W-1:0] load_val,
	output logic done,
	output logic near
);

	asr_tmr_t st_q;
	asr_tmr_t st_d;

	// Next count, plus flags one and zero cycles ahead.
	always_comb
	begin
		st_d = st_q;
		if (load)
			st_d.cnt = load_val;
		else if (st_q.cnt != 4'h0)
			st_d.cnt = st_q.cnt - 4'h1;
		st_d.done = (st_d.cnt == 4'h0);
		st_d.near = (st_d.cnt == 4'h1);
	end

	// Register the timer state.
	always_ff @(posedge clock)
	begin
		if (!rstn)
			st_q <= '{cnt: 4'h0, done: 1'b1, near: 1'b0};
		else
			st_q <= st_d;
	end

	assign done = st_q.done;
	assign near = st_q.near;

endmodule

// ### core/asr_ctrl.sv
// Purpose: Host sequencer for an asynchronous 64K by 4 static memory.
// Assumes: Memory inputs are synchronous to clock; dq_in is sampled direct.
// Notes: Writes lower the write strobe before select, so outputs stay off.
`timescale 1ns/1ns
`include "asr_defines.svh"

module asr_ctrl
	import asr_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic req_valid,
	input asr_req_t req,
	output logic req_ready,
	output logic [`ASR_DATA_W-1:0] rd_data,
	output logic rd_valid,
	output asr_pins_t pins,
	input wire logic [`ASR_DATA_W-1:0] dq_in
);

	// Whole state of the sequencer.
	typedef struct packed {
		asr_state_t state;
		asr_pins_t pins;
		logic ready;
		logic [`ASR_DATA_W-1:0] rdata;
		logic rvalid;
	} asr_ctrl_st_t;

	asr_ctrl_st_t st_q;
	asr_ctrl_st_t st_d;
	logic tmr_load;
	logic [`ASR_CNT_W-1:0] tmr_val;
	logic tmr_done;
	logic tmr_near;
	logic take;

	// Count of cycles for each phase, cut to the timer width.
	function automatic logic [`ASR_CNT_W-1:0] cyc(input int n);
		cyc = `ASR_CNT_W'(n);
	endfunction

	// Pins with the memory idle: deselected, strobe high, bus released.
	function automatic asr_pins_t idle_pins(input asr_pins_t p);
		asr_pins_t r;
		r = p;
		r.sel_n = 1'b1;
		r.we_n = 1'b1;
		r.dq_oe = 1'b0;
		idle_pins = r;
	endfunction

	// Phase timer shared by every state.
	asr_timer u_timer
	(
		.clock(clock),
		.rstn(rstn),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done),
		.near(tmr_near)
	);

	// A request is taken only while ready stands high.
	assign take = req_valid && st_q.ready;

	// Next state and pin values of the sequencer.
	always_comb
	begin
		st_d = st_q;
		st_d.rvalid = 1'b0;
		tmr_load = 1'b0;
		tmr_val = cyc(1);
		case (st_q.state)
			ASR_IDLE:
			begin
				st_d.ready = 1'b1;
				if (take)
				begin
					st_d.ready = 1'b0;
					st_d.pins.word_address_lines = req.addr;
					st_d.pins.dq_out = req.wdata;
					st_d.pins.dq_oe = 1'b0;
					tmr_load = 1'b1;
					if (req.we)
					begin
						st_d.pins.we_n = 1'b0;
						st_d.pins.sel_n = 1'b1;
						tmr_val = cyc(`ASR_CYC_FLOAT);
						st_d.state = ASR_WR_STROBE;
					end
					else
					begin
						st_d.pins.sel_n = 1'b0;
						st_d.pins.we_n = 1'b1;
						tmr_val = cyc(`ASR_CYC_READ_ACCESS);
						st_d.state = ASR_READ;
					end
				end
			end
			ASR_READ:
			begin
				st_d.ready = tmr_near;
				if (tmr_done)
				begin
					st_d.rdata = dq_in;
					st_d.rvalid = 1'b1;
					if (take && !req.we)
					begin
						st_d.pins.word_address_lines = req.addr;
						st_d.pins.dq_out = req.wdata;
						st_d.ready = 1'b0;
						tmr_load = 1'b1;
						tmr_val = cyc(`ASR_CYC_READ_ACCESS);
					end
					else if (take)
					begin
						// strobe high while address moves.
						// Lowering it here could start a stray
						// write if select rises late at the pins.
						st_d.pins.sel_n = 1'b1;
						st_d.pins.we_n = 1'b1;
						st_d.pins.word_address_lines = req.addr;
						st_d.pins.dq_out = req.wdata;
						st_d.ready = 1'b0;
						tmr_load = 1'b1;
						tmr_val = cyc(`ASR_CYC_FLOAT);
						st_d.state = ASR_WR_STROBE;
					end
					else
					begin
						st_d.pins = idle_pins(st_q.pins);
						st_d.ready = 1'b1;
						st_d.state = ASR_IDLE;
					end
				end
			end
			ASR_WR_STROBE:
			begin
				st_d.ready = 1'b0;
				// strobe falls on a settled address.
				st_d.pins.we_n = 1'b0;
				if (tmr_done)
				begin
					st_d.pins.sel_n = 1'b0;
					st_d.pins.dq_oe = 1'b1;
					tmr_load = 1'b1;
					tmr_val = cyc(`ASR_CYC_WRITE_LOW);
					st_d.state = ASR_WR_DATA;
				end
			end
			ASR_WR_DATA:
			begin
				st_d.ready = 1'b0;
				// both low for the full time.
				if (tmr_done)
				begin
					st_d.pins.sel_n = 1'b1;
					st_d.pins.we_n = 1'b1;
					tmr_load = 1'b1;
					tmr_val = cyc(`ASR_CYC_ADDR_HOLD);
					st_d.state = ASR_WR_HOLD;
				end
			end
			ASR_WR_HOLD:
			begin
				// address and data held past end.
				st_d.ready = tmr_done;
				if (tmr_done)
				begin
					st_d.pins = idle_pins(st_q.pins);
					st_d.state = ASR_IDLE;
				end
			end
			default:
			begin
				st_d.pins = idle_pins(st_q.pins);
				st_d.ready = 1'b0;
				st_d.state = ASR_IDLE;
			end
		endcase
	end

	// Register the sequencer state; reset leaves the memory deselected.
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			st_q.state <= ASR_IDLE;
			st_q.pins.sel_n <= 1'b1;
			st_q.pins.we_n <= 1'b1;
			st_q.pins.word_address_lines <= 16'h0000;
			st_q.pins.dq_out <= 4'h0;
			st_q.pins.dq_oe <= 1'b0;
			st_q.ready <= 1'b0;
			st_q.rdata <= 4'h0;
			st_q.rvalid <= 1'b0;
		end
		else
			st_q <= st_d;
	end

	// Outputs straight from the state register.
	assign pins = st_q.pins;
	assign req_ready = st_q.ready;
	assign rd_data = st_q.rdata;
	assign rd_valid = st_q.rvalid;

endmodule

// ### verification/asr_ctrl_sva.sv
// Purpose: Assertions on the static memory host ports.
// Assumes: Slowest grade counts from the defines header.
// Notes: Bound to every asr_ctrl instance.
`timescale 1ns/1ns
`include "asr_defines.svh"

module asr_ctrl_sva
	import asr_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic req_valid,
	input asr_req_t req,
	input wire logic req_ready,
	input wire logic [`ASR_DATA_W-1:0] rd_data,
	input wire logic rd_valid,
	input asr_pins_t pins,
	input wire logic [`ASR_DATA_W-1:0] dq_in
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);

	// Both strobes stay low together for the whole write.
	sequence both_low;
		(!pins.sel_n && !pins.we_n) [*6];
	endsequence

	// Write phase order and timing.
	chk_float_wait: assert property (
		$fell(pins.we_n) |-> !pins.dq_oe [*3])
		else $error("data driven before float time");
	chk_drive_in_write: assert property (
		$rose(pins.dq_oe) |-> !pins.we_n && !pins.sel_n)
		else $error("data driven outside a write");
	chk_write_length: assert property (
		$fell(pins.sel_n) && !pins.we_n |-> both_low)
		else $error("write shorter than its minimum");
	chk_end_together: assert property (
		$rose(pins.we_n) |-> $rose(pins.sel_n))
		else $error("strobes did not rise together");
	chk_addr_hold: assert property (
		$rose(pins.we_n) |=> $stable(pins.word_address_lines) [*2])
		else $error("address not held after write");
	// An address move needs one strobe high on both sides of the edge.
	chk_addr_move: assert property (
		$changed(pins.word_address_lines) |->
		(pins.we_n && $past(pins.we_n)) ||
		(pins.sel_n && $past(pins.sel_n)))
		else $error("address moved with both strobes low");
	// Read phase timing and capture, and one take per ready.
	chk_read_latency: assert property (
		$fell(pins.sel_n) && pins.we_n |-> ##7 rd_valid)
		else $error("read data late or early");
	chk_addr_stable: assert property (
		$fell(pins.sel_n) |=> $stable(pins.word_address_lines) [*6])
		else $error("address moved during access");
	chk_read_data: assert property (
		rd_valid |-> rd_data == $past(dq_in))
		else $error("read data not the sampled bus");
	chk_take_once: assert property (
		req_valid && req_ready |=> !req_ready)
		else $error("ready stayed high after a take");
endmodule

bind asr_ctrl asr_ctrl_sva u_sva (.clock(clock), .rstn(rstn),
	.req_valid(req_valid), .req(req), .req_ready(req_ready),
	.rd_data(rd_data), .rd_valid(rd_valid), .pins(pins), .dq_in(dq_in));

// ### verification/asr_sram_model.sv
// Purpose: Behavioural 64K by 4 static memory.
// Assumes: Slowest grade access time.
// Notes: Released lines show the inverse of the last value.
`timescale 1ns/1ns

module asr_sram_model
	import asr_pkg::*;
#(
	parameter int ACC_NS = 45
)
(
	input wire logic sel_n,
	input wire logic we_n,
	input wire logic [15:0] addr,
	input wire logic [3:0] din,
	output logic [3:0] q,
	output logic oe
);
	logic [3:0] mem [0:65535];
	logic [3:0] q_r = 4'h0;
	logic wr = 1'b0;
	// new access per address or select
	always @(addr or negedge sel_n)
	begin
		q_r = ~q_r;
		q_r <= #(ACC_NS) mem[addr];
	end
	// drive only when selected for a read
	always @(negedge sel_n) oe = we_n;
	// float on deselect or falling strobe
	always @(posedge sel_n or negedge we_n) oe = 1'b0;
	// output back on after a strobe-ended write
	always @(posedge we_n) #5 if (!sel_n && we_n) oe = 1'b1;
	// store at the end of both low
	always @(sel_n or we_n)
	begin
		if (!sel_n && !we_n)
			wr = 1'b1;
		else if (wr)
		begin
			mem[addr] = din;
			wr = 1'b0;
		end
	end
	assign q = oe ? q_r : ~q_r;
	initial oe = 1'b0;
endmodule

// ### verification/tb_asr_ctrl.sv
// Purpose: Self-checking bench for the static memory host.
// Assumes: Memory model on the data lines.
// Notes: Reads are collected in a queue as they complete.
`timescale 1ns/1ns

module tb_asr_ctrl
	import asr_pkg::*;
;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic req_valid = 1'b0;
	asr_req_t req = '0;
	logic req_ready, rd_valid, m_oe;
	logic [3:0] rd_data, m_q, dq;
	asr_pins_t pins;
	logic [3:0] rq[$];
	int failures = 0;
	int comparisons = 0;

	asr_ctrl dut (.clock(clock), .rstn(rstn), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .pins(pins), .dq_in(dq));
	asr_sram_model mem (.sel_n(pins.sel_n), .we_n(pins.we_n),
		.addr(pins.word_address_lines), .din(dq), .q(m_q), .oe(m_oe));
	// Wire level from the two drivers.
	assign dq = pins.dq_oe ? pins.dq_out : m_q;

	initial forever #4 clock = ~clock;

	// Finished reads, and a watch for two drivers at once.
	always @(posedge clock)
	begin
		if (rd_valid === 1'b1) rq.push_back(rd_data);
		if (rstn && pins.dq_oe === 1'b1 && m_oe === 1'b1)
			check(1, 0);
	end

	task finish_test;
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task send(input logic w, input logic [15:0] a, input logic [3:0] d);
		int n;
		n = 0;
		req_valid = 1'b1;
		req = '{we: w, addr: a, wdata: d};
		do
		begin
			@(posedge clock);
			n++;
		end
		while (req_ready !== 1'b1 && n < 40);
		// A request never taken ends the run.
		if (req_ready !== 1'b1)
		begin
			check(1, 0);
			finish_test();
		end
		#1;
	endtask

	task drain(input logic [3:0] exp[$]);
		int n;
		n = 0;
		req_valid = 1'b0;
		while (rq.size() < exp.size() && n < 60)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		// Missing reads end the run.
		if (rq.size() < exp.size())
		begin
			check(1, 0);
			finish_test();
		end
		foreach (exp[i])
			check(rq[i], exp[i]);
		rq = {};
	endtask

	// Words at both ends of the address range, then chained reads.
	task t_boundary;
		send(1, 16'h0000, 4'h5);
		send(1, 16'hffff, 4'ha);
		send(1, 16'h1234, 4'h3);
		send(0, 16'h0000, 4'h0);
		send(0, 16'hffff, 4'h0);
		send(0, 16'h1234, 4'h0);
		drain('{4'h5, 4'ha, 4'h3});
	endtask

	// A stored word replaced, then the memory left deselected.
	task t_overwrite;
		send(1, 16'h1234, 4'hc);
		send(0, 16'h0000, 4'h0);
		send(0, 16'h1234, 4'h0);
		drain('{4'h5, 4'hc});
		repeat (4) @(posedge clock);
		#1;
		check(pins.sel_n, 1);
		check(m_oe, 0);
	endtask

	// A write taken in the last cycle of a read, then read back.
	task t_turnaround;
		send(0, 16'hffff, 4'h0);
		send(1, 16'h8001, 4'h6);
		send(0, 16'h8001, 4'h0);
		drain('{4'ha, 4'h6});
	endtask

	initial
	begin
		repeat (16) @(posedge clock);
		#1 rstn = 1'b1;
		t_boundary();
		t_overwrite();
		t_turnaround();
		finish_test();
	end
endmodule
